// ==== rtl/qei_top.sv ====
// Quadrature encoder integration: pin conditioning, two encoder units, error routing
//
// What this block does
// [RULE1] Bit 9 of the clock-domain disable register stops the encoder units' clock domain and nothing else.
// [RULE2] After reset that bit is clear, so the encoder domain runs until software sets it.
// [RULE3] Each encoder unit raises its phase-error output when its A and B inputs change together.
// [RULE4] The phase-error outputs of both units meet in a selection multiplexer that picks one.
// [RULE5] The multiplexer output is inverted and driven to the high-end timer.
// [RULE6] Input A takes the synchronised path when word-8 bit 0 is 1, the filtered path when bit 0 is 0 and bit 1 is 1.
// [RULE7] Input B takes the synchronised path when word-8 bit 8 is 1, the filtered path when bit 8 is 0 and bit 9 is 1.
// [RULE8] Index takes the synchronised path when word-8 bit 16 is 1, the filtered path when bit 16 is 0 and bit 17 is 1.
// [RULE9] Strobe takes the synchronised path when word-8 bit 24 is 1, the filtered path when bit 24 is 0 and bit 25 is 1.
// [RULE10] The sensor holds index high and low at least 2 clocks each, plus the filter width when filtered.
// [RULE11] The sensor holds strobe high and low at least 2 clocks each, plus the filter width when filtered.
// [RULE12] A unit's counter moves no later than 4 clocks after the qualifying input edge; filtered inputs take 4 clocks plus the filter width.
// [RULE13] A unit's position-compare sync output follows the causing input edge within 6 clocks; filtered inputs take 4 clocks plus the filter width.
// [RULE14] Each synchronised path is two flops in series; the filtered path passes a level only once it held for the width.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qei_top
   import qei_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire qei_pins_t [QEI_UNITS-1:0] enc_pins,
   output logic [QEI_UNITS-1:0] phase_error_out,
   output logic het_phase_err_n,
   output logic [QEI_UNITS-1:0] pos_cmp_sync
);
   qei_state_t st_q;
   qei_state_t st_d;
   logic [QEI_IN_ALL-1:0] pin_vec;
   logic [QEI_IN_ALL-1:0] filt_sel;
   logic [QEI_IN_ALL-1:0] lvl;
   logic [QEI_EV_W-1:0] ev_set;
   logic [QEI_EV_W-1:0] ev_clr;
   logic enc_run;
   logic [31:0] cnt_nx;
   logic [1:0] ab_now;
   logic ch_a;
   logic ch_b;

   assign pin_vec = enc_pins;

   ////////////////////////////////////////////////////////////////////////////////
   // Input conditioning
   for (genvar i = 0; i < QEI_IN_ALL; i++) begin : g_in
      localparam int unsigned FB = QEI_PMX_STRIDE * (i % QEI_IN_PER_UNIT);
      // Sync when the sync bit is set or neither bit is set
      assign filt_sel[i] = !st_q.pin_mux8[FB + QEI_PMX_SYNC_OFS] && st_q.pin_mux8[FB + QEI_PMX_FILT_OFS]; // [RULE6] [RULE7] [RULE8] [RULE9]
      qei_in_cond u_cond (
         .hclk(hclk),
         .hresetn(hresetn),
         .pin(pin_vec[i]),
         .filt_en(filt_sel[i]),
         .filt_width(st_q.filt),
         .level(lvl[i])
      ); // [RULE14]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read mux
   function automatic logic [31:0] qei_read(
      input logic [7:0] a,
      input qei_state_t s,
      input logic [QEI_IN_ALL-1:0] lv
   );
      logic [31:0] r;
      r = '0;
      case (a)
         QEI_OFF_CLK_DIS: begin
            r = s.clk_dis;
         end
         QEI_OFF_PIN_MUX8: begin
            r = s.pin_mux8;
         end
         QEI_OFF_FILT: begin
            r[QEI_FILT_W-1:0] = s.filt;
         end
         QEI_OFF_ERRSEL: begin
            r[0] = s.errsel;
         end
         QEI_OFF_STAT: begin
            r[QEI_EV_W-1:0] = s.stat;
         end
         QEI_OFF_MASK: begin
            r[QEI_EV_W-1:0] = s.mask;
         end
         QEI_OFF_CNT0: begin
            r = s.cnt[0];
         end
         QEI_OFF_CNT1: begin
            r = s.cnt[1];
         end
         QEI_OFF_CMP0: begin
            r = s.cmp[0];
         end
         QEI_OFF_CMP1: begin
            r = s.cmp[1];
         end
         QEI_OFF_LAT0: begin
            r = s.lat[0];
         end
         QEI_OFF_LAT1: begin
            r = s.lat[1];
         end
         QEI_OFF_INSTAT: begin
            r[QEI_IN_ALL-1:0] = lv;
            r[QEI_INSTAT_ERR_POS +: QEI_UNITS] = s.err;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction : qei_read

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      ev_set = '0;
      ev_clr = '0;
      cnt_nx = '0;
      ab_now = '0;
      ch_a = 1'b0;
      ch_b = 1'b0;
      enc_run = !st_q.clk_dis[QEI_CLK_DIS_ENC_BIT]; // [RULE1] [RULE2]

      // Data phase of a bus write
      if (st_q.wr_pend) begin
         case (st_q.waddr)
            QEI_OFF_CLK_DIS: begin
               st_d.clk_dis = hwdata; // [RULE1]
            end
            QEI_OFF_PIN_MUX8: begin
               st_d.pin_mux8 = hwdata;
            end
            QEI_OFF_FILT: begin
               st_d.filt = hwdata[QEI_FILT_W-1:0];
            end
            QEI_OFF_ERRSEL: begin
               st_d.errsel = hwdata[0];
            end
            QEI_OFF_STAT: begin
               ev_clr = hwdata[QEI_EV_W-1:0];
            end
            QEI_OFF_MASK: begin
               st_d.mask = hwdata[QEI_EV_W-1:0];
            end
            QEI_OFF_CMP0: begin
               st_d.cmp[0] = hwdata;
            end
            QEI_OFF_CMP1: begin
               st_d.cmp[1] = hwdata;
            end
            default: begin
            end
         endcase
      end

      // Encoder units
      for (int u = 0; u < QEI_UNITS; u++) begin
         cnt_nx = st_q.cnt[u];
         ab_now = {lvl[u * QEI_IN_PER_UNIT + QEI_IN_B], lvl[u * QEI_IN_PER_UNIT + QEI_IN_A]};
         ch_a = ab_now[0] ^ st_q.pab[u][0];
         ch_b = ab_now[1] ^ st_q.pab[u][1];
         st_d.cmp_out[u] = 1'b0;
         if (enc_run) begin // [RULE1]
            st_d.pab[u] = ab_now;
            st_d.pidx[u] = lvl[u * QEI_IN_PER_UNIT + QEI_IN_IDX];
            st_d.pstb[u] = lvl[u * QEI_IN_PER_UNIT + QEI_IN_STB];
            if (ch_a && ch_b) begin
               ev_set[u * QEI_EV_PER_UNIT + QEI_EV_PERR] = 1'b1; // [RULE3]
            end else if (ch_a || ch_b) begin
               if (ab_now[0] ^ st_q.pab[u][1]) begin
                  cnt_nx = st_q.cnt[u] + 32'h1; // [RULE12]
               end else begin
                  cnt_nx = st_q.cnt[u] - 32'h1; // [RULE12]
               end
            end
            if (lvl[u * QEI_IN_PER_UNIT + QEI_IN_IDX] && !st_q.pidx[u]) begin
               cnt_nx = '0;
               ev_set[u * QEI_EV_PER_UNIT + QEI_EV_IDX] = 1'b1;
            end
            if (lvl[u * QEI_IN_PER_UNIT + QEI_IN_STB] && !st_q.pstb[u]) begin
               st_d.lat[u] = st_q.cnt[u];
               ev_set[u * QEI_EV_PER_UNIT + QEI_EV_STB] = 1'b1;
            end
            if ((cnt_nx != st_q.cnt[u]) && (cnt_nx == st_q.cmp[u])) begin
               st_d.cmp_out[u] = 1'b1; // [RULE13]
               ev_set[u * QEI_EV_PER_UNIT + QEI_EV_CMP] = 1'b1;
            end
         end
         // Software load of the counter wins over counting
         if (st_q.wr_pend && (st_q.waddr == 8'(QEI_OFF_CNT0 + QEI_UNIT_STRIDE * 8'(u)))) begin
            cnt_nx = hwdata;
         end
         st_d.cnt[u] = cnt_nx;
         // Error flag: a new error beats a clear in the same cycle
         st_d.err[u] = (st_q.err[u] && !ev_clr[u * QEI_EV_PER_UNIT + QEI_EV_PERR])
            || ev_set[u * QEI_EV_PER_UNIT + QEI_EV_PERR]; // [RULE3]
      end

      // Sticky status, set beats clear
      st_d.stat = (st_q.stat & ~ev_clr) | ev_set;
      st_d.irq = |(st_d.stat & st_d.mask);

      // Error select and inversion toward the timer
      st_d.het_phase_err_n = !(st_d.errsel ? st_d.err[1] : st_d.err[0]); // [RULE4] [RULE5]

      // Address phase
      st_d.hreadyout = 1'b1;
      st_d.hresp = 1'b0;
      st_d.wr_pend = 1'b0;
      if (hsel && hready && htrans[QEI_HTRANS_ACT_BIT]) begin
         st_d.waddr = haddr[7:0];
         if (hwrite) begin
            st_d.wr_pend = (hsize == QEI_HSIZE_WORD);
         end else begin
            st_d.hrdata = qei_read(haddr[7:0], st_d, lvl);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= QEI_ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata = st_q.hrdata;
   assign hreadyout = st_q.hreadyout;
   assign hresp = st_q.hresp;
   assign irq = st_q.irq;
   assign phase_error_out = st_q.err;
   assign het_phase_err_n = st_q.het_phase_err_n;
   assign pos_cmp_sync = st_q.cmp_out;
endmodule : qei_top
`default_nettype wire

// ==== common/qei_pkg.sv ====
// Shared constants, register map and carrier types of the encoder integration
package qei_pkg;
   // Units, inputs and timing
   localparam int unsigned QEI_UNITS = 2;
   localparam int unsigned QEI_IN_PER_UNIT = 4;
   localparam int unsigned QEI_IN_ALL = QEI_UNITS * QEI_IN_PER_UNIT;
   localparam int unsigned QEI_IN_A = 0;
   localparam int unsigned QEI_IN_B = 1;
   localparam int unsigned QEI_IN_IDX = 2;
   localparam int unsigned QEI_IN_STB = 3;
   localparam int unsigned QEI_CLK_PERIOD_NS = 20;
   localparam int unsigned QEI_SYNC_STAGES = 2;
   localparam int unsigned QEI_MIN_HOLD_CYC = 2;
   localparam int unsigned QEI_CNT_LAT_MAX_CYC = 4;
   localparam int unsigned QEI_CMP_LAT_MAX_CYC = 6;
   localparam int unsigned QEI_FILT_W = 4;
   // Register byte offsets
   localparam logic [7:0] QEI_OFF_CLK_DIS = 8'h00;
   localparam logic [7:0] QEI_OFF_PIN_MUX8 = 8'h04;
   localparam logic [7:0] QEI_OFF_FILT = 8'h08;
   localparam logic [7:0] QEI_OFF_ERRSEL = 8'h0c;
   localparam logic [7:0] QEI_OFF_STAT = 8'h10;
   localparam logic [7:0] QEI_OFF_MASK = 8'h14;
   localparam logic [7:0] QEI_OFF_CNT0 = 8'h18;
   localparam logic [7:0] QEI_OFF_CNT1 = 8'h1c;
   localparam logic [7:0] QEI_OFF_CMP0 = 8'h20;
   localparam logic [7:0] QEI_OFF_CMP1 = 8'h24;
   localparam logic [7:0] QEI_OFF_LAT0 = 8'h28;
   localparam logic [7:0] QEI_OFF_LAT1 = 8'h2c;
   localparam logic [7:0] QEI_OFF_INSTAT = 8'h30;
   localparam logic [7:0] QEI_UNIT_STRIDE = 8'h04;
   // Field positions
   localparam int unsigned QEI_CLK_DIS_ENC_BIT = 9;
   localparam int unsigned QEI_PMX_STRIDE = 8;
   localparam int unsigned QEI_PMX_SYNC_OFS = 0;
   localparam int unsigned QEI_PMX_FILT_OFS = 1;
   localparam int unsigned QEI_EV_PER_UNIT = 4;
   localparam int unsigned QEI_EV_W = QEI_UNITS * QEI_EV_PER_UNIT;
   localparam int unsigned QEI_EV_PERR = 0;
   localparam int unsigned QEI_EV_CMP = 1;
   localparam int unsigned QEI_EV_IDX = 2;
   localparam int unsigned QEI_EV_STB = 3;
   localparam int unsigned QEI_INSTAT_ERR_POS = 8;
   // Reset values
   localparam logic [31:0] QEI_CLK_DIS_RST = 32'h0000_0000;
   localparam logic [31:0] QEI_PIN_MUX8_RST = 32'h0101_0101;
   localparam logic [QEI_FILT_W-1:0] QEI_FILT_RST = 4'h0;
   // Bus encodings
   localparam logic [2:0] QEI_HSIZE_WORD = 3'h2;
   localparam int unsigned QEI_HTRANS_ACT_BIT = 1;

   typedef struct packed {
      logic encoder_strobe_pin;
      logic encoder_index_pin;
      logic encoder_b_pin;
      logic encoder_a_pin;
   } qei_pins_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic filt;
      logic [QEI_FILT_W-1:0] cnt;
   } qei_cond_st_t;

   localparam qei_cond_st_t QEI_COND_RST = '{default: '0};

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic irq;
      logic het_phase_err_n;
      logic wr_pend;
      logic [7:0] waddr;
      logic [31:0] clk_dis;
      logic [31:0] pin_mux8;
      logic [QEI_FILT_W-1:0] filt;
      logic errsel;
      logic [QEI_EV_W-1:0] stat;
      logic [QEI_EV_W-1:0] mask;
      logic [QEI_UNITS-1:0][31:0] cnt;
      logic [QEI_UNITS-1:0][31:0] cmp;
      logic [QEI_UNITS-1:0][31:0] lat;
      logic [QEI_UNITS-1:0][1:0] pab;
      logic [QEI_UNITS-1:0] pidx;
      logic [QEI_UNITS-1:0] pstb;
      logic [QEI_UNITS-1:0] err;
      logic [QEI_UNITS-1:0] cmp_out;
   } qei_state_t;

   localparam qei_state_t QEI_ST_RST = '{hreadyout: 1'b1, het_phase_err_n: 1'b1,
      clk_dis: QEI_CLK_DIS_RST, pin_mux8: QEI_PIN_MUX8_RST, filt: QEI_FILT_RST, default: '0};
endpackage : qei_pkg

// ==== rtl/qei_in_cond.sv ====
// Input conditioner: two-stage synchroniser with optional stability filter
`timescale 1ns/1ps
`default_nettype none
module qei_in_cond
   import qei_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic filt_en,
   input wire logic [QEI_FILT_W-1:0] filt_width,
   output logic level
);
   qei_cond_st_t st_q;
   qei_cond_st_t st_d;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.sync1 = pin; // [RULE14]
      st_d.sync2 = st_q.sync1; // [RULE14]
      if (st_q.sync2 != st_q.filt) begin
         if (st_q.cnt >= filt_width) begin
            st_d.filt = st_q.sync2; // [RULE14]
            st_d.cnt = '0;
         end else begin
            st_d.cnt = st_q.cnt + 4'h1;
         end
      end else begin
         st_d.cnt = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= QEI_COND_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Path select
   assign level = filt_en ? st_q.filt : st_q.sync2;
endmodule : qei_in_cond
`default_nettype wire

// ==== verification/qei_sensor_model.sv ====
// Behavioural quadrature sensor driving the encoder pins
`timescale 1ns/1ps
`default_nettype none
module qei_sensor_model
   import qei_pkg::*;
(
   input wire logic hclk,
   output var qei_pins_t [QEI_UNITS-1:0] pins
);
   int ph [QEI_UNITS] = '{default: 0};
   initial begin
      pins = '0;
   end
   ////////////////////////////////////////////////////////////
   // Gray step; dir of 2 moves A and B together
   task automatic step(input int u, input int dir, input int n);
      ph[u] = (ph[u] + dir) & 3;
      pins[u].encoder_a_pin <= (ph[u] == 1 || ph[u] == 2);
      pins[u].encoder_b_pin <= (ph[u] >= 2);
      repeat (n) @(posedge hclk);
   endtask : step
   // Index or strobe pulse, 20 clocks high then 20 low
   task automatic pulse(input int u, input bit stb);
      for (int i = 0; i < 2; i++) begin
         if (stb) pins[u].encoder_strobe_pin <= (i == 0);
         else pins[u].encoder_index_pin <= (i == 0);
         repeat (20) @(posedge hclk);
      end
   endtask : pulse
endmodule : qei_sensor_model
`default_nettype wire

// ==== verification/qei_top_sva.sv ====
// Port-level checks of the encoder integration
`timescale 1ns/1ps
`default_nettype none
module qei_top_sva
   import qei_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire qei_pins_t [QEI_UNITS-1:0] enc_pins,
   input wire logic [QEI_UNITS-1:0] phase_error_out,
   input wire logic het_phase_err_n,
   input wire logic [QEI_UNITS-1:0] pos_cmp_sync
);
   qei_pins_t prev_q;
   logic [3:0] since_q;
   // Clocks since unit 0 pins last moved
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '0;
         since_q <= 4'hf;
      end else begin
         prev_q <= enc_pins[0];
         if (enc_pins[0] != prev_q) since_q <= 4'h0;
         else if (since_q != 4'hf) since_q <= since_q + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_ab_jump;
      $changed(enc_pins[0].encoder_a_pin) && $changed(enc_pins[0].encoder_b_pin);
   endsequence
   sequence s_one_pulse;
      pos_cmp_sync[0] ##1 !pos_cmp_sync[0];
   endsequence
   a_perr_detect: assert property (s_ab_jump |-> ##[1:24] phase_error_out[0])
      else $error("phase error not flagged");
   a_perr_sticky: assert property ($fell(phase_error_out[0]) |-> $past(hsel && htrans[1] && hwrite, 2))
      else $error("phase error dropped without write");
   a_het_select: assert property ($fell(het_phase_err_n) |-> |phase_error_out)
      else $error("timer error without source");
   a_het_idle: assert property (!(|phase_error_out) && $past(!(|phase_error_out)) |-> het_phase_err_n)
      else $error("timer error line low while idle");
   a_cmp_single: assert property ($rose(pos_cmp_sync[0]) |-> s_one_pulse)
      else $error("compare pulse not one cycle");
   a_cmp_latency: assert property (pos_cmp_sync[0] |-> since_q <= 4'h5)
      else $error("compare pulse too late");
   a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
      else $error("read data moved");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or errored");
endmodule : qei_top_sva
bind qei_top qei_top_sva i_qei_top_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
   .hreadyout, .hresp, .enc_pins, .phase_error_out, .het_phase_err_n, .pos_cmp_sync);
`default_nettype wire

// ==== verification/qei_tb_top.sv ====
// Self-checking bench of the encoder integration
`timescale 1ns/1ps
`default_nettype none
module qei_tb_top
   import qei_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq, het_phase_err_n;
   logic [QEI_UNITS-1:0] phase_error_out, pos_cmp_sync;
   qei_pins_t [QEI_UNITS-1:0] enc_pins;
   logic [31:0] rv;
   logic [31:0] modes [4] = '{32'h0101_0101, 32'h0202_0202, 32'h0, 32'h0303_0303};
   int miscompares = 0;
   int tests_run = 0;
   int seed = 3839;
   int cnt_m = 0;
   int k, n;
   always #10 hclk = ~hclk;
   qei_top i_qei_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(QEI_HSIZE_WORD),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq, .enc_pins, .phase_error_out,
      .het_phase_err_n, .pos_cmp_sync);
   qei_sensor_model i_qei_sensor_model (.hclk, .pins(enc_pins));
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wait_rdy();
      int c = 0;
      do begin
         @(posedge hclk);
         c++;
      end while (hreadyout !== 1'b1 && c < 50);
      if (c >= 50) begin
         miscompares++;
         print_verdict();
      end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rv = hrdata;
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rv, e);
   endtask : rdc
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(QEI_OFF_CLK_DIS, 32'h0);
      rdc(QEI_OFF_PIN_MUX8, 32'h0101_0101);
      rdc(8'h3c, 32'h0);
      chk(het_phase_err_n, 32'h1);
      $display("test reset done");
      bus(1'b1, QEI_OFF_FILT, 32'h3);
      foreach (modes[m]) begin
         bus(1'b1, QEI_OFF_PIN_MUX8, modes[m]);
         k = 1 + ($unsigned($random(seed)) % 4);
         for (int i = 0; i < k; i++) begin
            i_qei_sensor_model.step(0, 1, 3);
            if (i == 0) rdc(QEI_OFF_CNT0, cnt_m + (m != 1));
            cnt_m++;
            repeat (12) @(posedge hclk);
         end
         rdc(QEI_OFF_CNT0, cnt_m);
         $display("test mode %0d done", m);
      end
      bus(1'b1, QEI_OFF_CMP0, cnt_m + 1);
      i_qei_sensor_model.step(0, 1, 0);
      cnt_m++;
      n = 0;
      while (pos_cmp_sync[0] !== 1'b1 && n < 7) begin
         @(negedge hclk);
         n++;
      end
      chk(n < 7, 32'h1);
      repeat (8) @(posedge hclk);
      rdc(QEI_OFF_STAT, 32'h2);
      bus(1'b1, QEI_OFF_STAT, 32'hff);
      i_qei_sensor_model.pulse(0, 1'b1);
      rdc(QEI_OFF_LAT0, cnt_m);
      i_qei_sensor_model.pulse(0, 1'b0);
      cnt_m = 0;
      rdc(QEI_OFF_CNT0, 32'h0);
      rdc(QEI_OFF_STAT, 32'hc);
      bus(1'b1, QEI_OFF_STAT, 32'hff);
      $display("test compare and pulses done");
      i_qei_sensor_model.step(0, 2, 12);
      chk({irq, phase_error_out, het_phase_err_n}, 32'h2);
      bus(1'b1, QEI_OFF_MASK, 32'h1);
      bus(1'b1, QEI_OFF_ERRSEL, 32'h1);
      repeat (2) @(posedge hclk);
      chk({irq, het_phase_err_n}, 32'h3);
      bus(1'b1, QEI_OFF_STAT, 32'h1);
      repeat (2) @(posedge hclk);
      chk({irq, phase_error_out}, 32'h0);
      rdc(QEI_OFF_CNT0, cnt_m);
      $display("test phase error done");
      bus(1'b1, QEI_OFF_CLK_DIS, 32'h200);
      rdc(QEI_OFF_CLK_DIS, 32'h200);
      i_qei_sensor_model.step(0, 1, 10);
      rdc(QEI_OFF_CNT0, cnt_m);
      i_qei_sensor_model.step(0, -1, 10);
      bus(1'b1, QEI_OFF_CLK_DIS, 32'h0);
      i_qei_sensor_model.step(0, 1, 10);
      rdc(QEI_OFF_CNT0, cnt_m + 1);
      $display("test clock gate done");
      bus(1'b1, QEI_OFF_CNT1, 32'h10);
      bus(1'b1, QEI_OFF_CMP1, 32'h11);
      i_qei_sensor_model.step(1, 1, 0);
      n = 0;
      while (pos_cmp_sync[1] !== 1'b1 && n < 7) begin
         @(negedge hclk);
         n++;
      end
      chk(n < 7, 32'h1);
      repeat (4) @(posedge hclk);
      rdc(QEI_OFF_CNT1, 32'h11);
      i_qei_sensor_model.step(1, 2, 12);
      chk({irq, phase_error_out, het_phase_err_n}, 32'h4);
      rdc(QEI_OFF_INSTAT, 32'h200 | 32'(enc_pins));
      $display("test second unit done");
      print_verdict();
   end
endmodule : qei_tb_top
`default_nettype wire
